// [flash_status_defines.vh]
// constants for the flash status and write protection block
`ifndef FLASH_STATUS_DEFINES_VH
`define FLASH_STATUS_DEFINES_VH
// ==========================================================
// status bit positions
`define ST_BUSY_POS     0
`define ST_WEL_POS      1
`define ST_BP0_POS      2
`define ST_BP2_POS      4
`define ST_TB_POS       5
`define ST_RSVD_POS     6
`define ST_LOCK_POS     7
// ==========================================================
// reset values
`define ST_NV_RESET     5'h00
`define ST_WORD_RESET   8'h00
// ==========================================================
// opcodes
`define OP_WREN         8'h06
`define OP_VWREN        8'h50
`define OP_WRDI         8'h04
`define OP_RDSR         8'h05
`define OP_WRSR         8'h01
`define OP_PP           8'h02
`define OP_SE           8'h20
`define OP_BE32         8'h52
`define OP_BE64         8'hd8
`define OP_CE1          8'hc7
`define OP_CE2          8'h60
// ==========================================================
// protected region boundaries
`define ADDR_TOP        24'h07ffff
`define ADDR_UP_1_8     24'h070000
`define ADDR_UP_1_4     24'h060000
`define ADDR_UP_1_2     24'h040000
`define ADDR_LO_1_8     24'h00ffff
`define ADDR_LO_1_4     24'h01ffff
`define ADDR_LO_1_2     24'h03ffff
// ==========================================================
// region sizes minus one per program or erase kind
`define SZ_SECTOR       24'h000fff
`define SZ_BLK32        24'h007fff
`define SZ_BLK64        24'h00ffff
`define SZ_PAGE         24'h0000ff
// ==========================================================
// internal operation times in cycles
`define T_WRSR_CYC      32'd200
`define T_PROG_CYC      32'd400
`define T_ERASE_CYC     32'd1000
`endif

// [flash_status_wp.v]
// spi status word, write enable latch and write protection logic
`timescale 1ns/1ps
`include "flash_status_defines.vh"

// Overview of operation
// - busy flag at bit zero during operations
// - while busy only status read served
// - busy clears when operation completes
// - write enable latch at bit one
// - latch cleared at reset and after writes
// - three range bits, written by status write
// - range bits reset to zero, none protected
// - range locked when lock set, pin low
// - direction bit picks top or bottom
// - direction bit nonvolatile, same lock rules
// - reserved bit six always reads zero
// - lock bit at seven, zero ignores pin
// - lock one: pin low rejects status write
// - top direction regions from given addresses
// - bottom direction regions up to given addresses
// - top range bit protects all, zero none
// - writes into protected regions are discarded
// - frame opens on select fall, msb first
// - frame ends on select rise
// - mid byte deselect abandons write instructions
// - opcode 06h sets write enable latch
// - writes need latch set beforehand
// - opcode 50h allows volatile status write
// - status byte repeats until deselect
module flash_status_wp #(
	parameter WRSR_CYC  = `T_WRSR_CYC,  // status write time
	parameter PROG_CYC  = `T_PROG_CYC,  // page program time
	parameter ERASE_CYC = `T_ERASE_CYC  // erase time
) (
	input  wire        sys_clk,              // block clock
	input  wire        resetn,               // sync reset, low
	input  wire        chip_select_n,        // spi select pin
	input  wire        serial_clk,           // spi clock pin
	input  wire        serial_in,            // spi data in pin
	input  wire        write_protect_pin_n,  // write protect pin
	output reg         serial_out,           // spi data out
	output reg         serial_out_oe_n,      // out enable, low
	output reg  [7:0]  flash_status_word,    // status mirror
	output reg         array_op_start,       // pulse: op accepted
	output reg  [7:0]  array_op_code,        // accepted opcode
	output reg  [23:0] array_op_addr         // accepted address
);

	// ==========================================================
	// pin synchronisers
	reg [2:0] cs_sync_q;   // select chain
	reg [2:0] sck_sync_q;  // clock chain
	reg [2:0] si_sync_q;   // data chain
	reg [2:0] wp_sync_q;   // protect pin chain
	reg       cs_n_q;      // agreed select level
	reg       sck_q;       // agreed clock level
	reg       si_q;        // agreed data level
	reg       wp_n_q;      // agreed protect level

	// three stages, level moves once the last two agree
	always @(posedge sys_clk) begin
		if (!resetn) begin
			cs_sync_q  <= 3'h7;
			sck_sync_q <= 3'h0;
			si_sync_q  <= 3'h0;
			wp_sync_q  <= 3'h7;
			cs_n_q     <= 1'b1;
			sck_q      <= 1'b0;
			si_q       <= 1'b0;
			wp_n_q     <= 1'b1;
		end else begin
			cs_sync_q  <= {cs_sync_q[1:0], chip_select_n};
			sck_sync_q <= {sck_sync_q[1:0], serial_clk};
			si_sync_q  <= {si_sync_q[1:0], serial_in};
			wp_sync_q  <= {wp_sync_q[1:0], write_protect_pin_n};
			if (cs_sync_q[2] == cs_sync_q[1])
				cs_n_q <= cs_sync_q[2];
			if (sck_sync_q[2] == sck_sync_q[1])
				sck_q <= sck_sync_q[2];
			if (si_sync_q[2] == si_sync_q[1])
				si_q <= si_sync_q[2];
			if (wp_sync_q[2] == wp_sync_q[1])
				wp_n_q <= wp_sync_q[2];
		end
	end

	// edge detection on agreed levels
	wire sck_new  = (sck_sync_q[2] == sck_sync_q[1]) ? sck_sync_q[2] : sck_q;
	wire cs_new   = (cs_sync_q[2] == cs_sync_q[1]) ? cs_sync_q[2] : cs_n_q;
	wire sck_rise = !sck_q && sck_new;   // sample edge
	wire sck_fall = sck_q && !sck_new;   // shift out edge
	wire cs_fall  = cs_n_q && !cs_new;   // frame start
	wire cs_rise  = !cs_n_q && cs_new;   // frame end
	wire si_new   = (si_sync_q[2] == si_sync_q[1]) ? si_sync_q[2] : si_q;

	// ==========================================================
	// status state
	reg        busy_q;              // internal op running
	reg        write_enable_latch_q;
	reg [2:0]  protect_range_q;     // range bits 2..0
	reg        protect_from_bottom_q;
	reg        status_lock_bit_q;
	reg        volatile_en_q;       // 50h seen
	reg [31:0] busy_cnt_q;          // remaining op cycles

	// live status byte, reserved bit forced to zero
	// latch at bit one, reserved zero
	wire [7:0] status_now = {status_lock_bit_q, 1'b0,
		protect_from_bottom_q, protect_range_q,
		write_enable_latch_q, busy_q};

	// ==========================================================
	// protection check of a target range
	// direction and region table
	function prot_hit;
		input [2:0]  bp;
		input        tb;
		input [23:0] lo;
		input [23:0] hi;
		reg   [23:0] plo;
		reg   [23:0] phi;
		reg          none;
		begin
			none = 1'b0;
			plo  = 24'h000000;
			phi  = `ADDR_TOP;
			if (bp == 3'h0)
				none = 1'b1;
			else if (!bp[2]) begin
				case (bp[1:0])
					2'h1: begin
						plo = tb ? 24'h000000 : `ADDR_UP_1_8;
						phi = tb ? `ADDR_LO_1_8 : `ADDR_TOP;
					end
					2'h2: begin
						plo = tb ? 24'h000000 : `ADDR_UP_1_4;
						phi = tb ? `ADDR_LO_1_4 : `ADDR_TOP;
					end
					default: begin
						plo = tb ? 24'h000000 : `ADDR_UP_1_2;
						phi = tb ? `ADDR_LO_1_2 : `ADDR_TOP;
					end
				endcase
			end
			prot_hit = !none && (lo <= phi) && (hi >= plo);
		end
	endfunction

	// ==========================================================
	// frame decoder
	localparam ST_IDLE = 4'b0001;  // waiting for select
	localparam ST_OPC  = 4'b0010;  // shifting opcode
	localparam ST_ARG  = 4'b0100;  // shifting argument bytes
	localparam ST_SKIP = 4'b1000;  // ignore rest of frame

	reg [3:0]  state_q;
	reg [7:0]  shift_q;     // incoming byte
	reg [2:0]  bit_cnt_q;   // bits taken in byte
	reg [7:0]  opcode_q;
	reg [2:0]  byte_cnt_q;  // argument bytes taken
	reg [23:0] addr_q;
	reg [7:0]  wrsr_data_q;
	reg [7:0]  out_shift_q; // status byte being sent
	reg        reading_q;   // status read active

	wire [7:0] byte_in = {shift_q[6:0], si_new};
	wire       byte_done = sck_rise && (bit_cnt_q == 3'h7);
	wire       hw_locked = status_lock_bit_q && !wp_n_q;
	wire       is_erase_op = (opcode_q == `OP_SE) ||
		(opcode_q == `OP_BE32) || (opcode_q == `OP_BE64);

	// target range per opcode
	reg [23:0] span;
	always @* begin
		span = `SZ_PAGE;
		case (opcode_q)
			`OP_SE:   span = `SZ_SECTOR;
			`OP_BE32: span = `SZ_BLK32;
			`OP_BE64: span = `SZ_BLK64;
			default:  span = `SZ_PAGE;
		endcase
	end
	wire [23:0] tgt_lo = addr_q & ~span;
	wire [23:0] tgt_hi = tgt_lo | span;

	// main sequencer
	always @(posedge sys_clk) begin
		if (!resetn) begin
			state_q               <= ST_IDLE;
			shift_q               <= 8'h00;
			bit_cnt_q             <= 3'h0;
			opcode_q              <= 8'h00;
			byte_cnt_q            <= 3'h0;
			addr_q                <= 24'h000000;
			wrsr_data_q           <= 8'h00;
			out_shift_q           <= 8'h00;
			reading_q             <= 1'b0;
			busy_q                <= 1'b0;
			busy_cnt_q            <= 32'd0;
			write_enable_latch_q  <= 1'b0;
			protect_range_q       <= 3'h0;
			protect_from_bottom_q <= 1'b0;
			status_lock_bit_q     <= 1'b0;
			volatile_en_q         <= 1'b0;
			serial_out            <= 1'b0;
			serial_out_oe_n       <= 1'b1;
			flash_status_word     <= `ST_WORD_RESET;
			array_op_start        <= 1'b0;
			array_op_code         <= 8'h00;
			array_op_addr         <= 24'h000000;
		end else begin
			array_op_start    <= 1'b0;
			flash_status_word <= status_now;
			if (busy_q) begin
				if (busy_cnt_q <= 32'd1) begin
					busy_q               <= 1'b0;
					write_enable_latch_q <= 1'b0;
				end
				busy_cnt_q <= busy_cnt_q - 32'd1;
			end
			if (sck_rise)
				shift_q <= byte_in;
			if (sck_rise)
				bit_cnt_q <= bit_cnt_q + 3'h1;
			// repeat status byte, fresh copy per byte
			if (reading_q && sck_fall) begin
				serial_out_oe_n <= 1'b0;
				// byte boundary follows the bit count, not the data
				if (bit_cnt_q == 3'h0) begin
					serial_out  <= status_now[7];
					out_shift_q <= {status_now[6:0], 1'b0};
				end else begin
					serial_out  <= out_shift_q[7];
					out_shift_q <= {out_shift_q[6:0], 1'b0};
				end
			end
			case (state_q)
				ST_IDLE: begin
					if (cs_fall) begin
						state_q   <= ST_OPC;
						bit_cnt_q <= 3'h0;
					end
				end
				ST_OPC: begin
					if (byte_done) begin
						opcode_q   <= byte_in;
						byte_cnt_q <= 3'h0;
						state_q    <= ST_SKIP;
						if (byte_in == `OP_RDSR) begin
							reading_q   <= 1'b1;
							out_shift_q <= status_now;
						end else if (!busy_q) begin
							state_q <= ST_ARG;
						end
					end
				end
				ST_ARG: begin
					if (byte_done) begin
						// saturate so long program data never wraps
						if (byte_cnt_q != 3'h7)
							byte_cnt_q <= byte_cnt_q + 3'h1;
						if (byte_cnt_q == 3'h0)
							wrsr_data_q <= byte_in;
						if (byte_cnt_q < 3'h3)
							addr_q <= {addr_q[15:0], byte_in};
					end
				end
				default: begin
				end
			endcase
			if (cs_rise) begin
				state_q         <= ST_IDLE;
				reading_q       <= 1'b0;
				serial_out_oe_n <= 1'b1;
				if (state_q == ST_ARG && bit_cnt_q == 3'h0) begin
					case (opcode_q)
						`OP_WREN: if (byte_cnt_q == 3'h0)
							write_enable_latch_q <= 1'b1;
						`OP_VWREN: if (byte_cnt_q == 3'h0)
							volatile_en_q <= 1'b1;
						`OP_WRDI: if (byte_cnt_q == 3'h0)
							write_enable_latch_q <= 1'b0;
						`OP_WRSR: begin
							if (byte_cnt_q != 3'h0 &&
								(write_enable_latch_q || volatile_en_q) &&
								!hw_locked) begin
								status_lock_bit_q <= wrsr_data_q[`ST_LOCK_POS];
								protect_from_bottom_q <=
									wrsr_data_q[`ST_TB_POS];
								protect_range_q <=
									wrsr_data_q[`ST_BP2_POS:`ST_BP0_POS];
								busy_q <= write_enable_latch_q;
								busy_cnt_q <= WRSR_CYC;
								volatile_en_q <= 1'b0;
							end
						end
						`OP_CE1, `OP_CE2: begin
							if (byte_cnt_q == 3'h0 && write_enable_latch_q &&
								protect_range_q == 3'h0) begin
								busy_q         <= 1'b1;
								busy_cnt_q     <= ERASE_CYC;
								array_op_start <= 1'b1;
								array_op_code  <= opcode_q;
								array_op_addr  <= 24'h000000;
							end
						end
						default: begin
							if ((opcode_q == `OP_PP || is_erase_op) &&
								byte_cnt_q >= 3'h3 && write_enable_latch_q &&
								!prot_hit(protect_range_q,
									protect_from_bottom_q, tgt_lo, tgt_hi)) begin
								busy_q         <= 1'b1;
								busy_cnt_q     <= is_erase_op ? ERASE_CYC
									: PROG_CYC;
								array_op_start <= 1'b1;
								array_op_code  <= opcode_q;
								array_op_addr  <= addr_q;
							end
						end
					endcase
				end
			end
		end
	end

endmodule // flash_status_wp

// [flash_status_wp_properties.sv]
// checker for the status word and write protection block
`timescale 1ns/1ps
`include "flash_status_defines.vh"
module flash_status_wp_properties #(
	parameter WRSR_CYC  = 200, // status write time
	parameter PROG_CYC  = 400, // program time
	parameter ERASE_CYC = 1000 // erase time
) (
	input wire        sys_clk,
	input wire        resetn,
	input wire        chip_select_n,
	input wire        serial_clk,
	input wire        serial_in,
	input wire        write_protect_pin_n,
	input wire        serial_out,
	input wire        serial_out_oe_n,
	input wire [7:0]  flash_status_word,
	input wire        array_op_start,
	input wire [7:0]  array_op_code,
	input wire [23:0] array_op_addr
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	// ==========================================================
	// busy length counter
	logic [15:0] busy_cnt_q; // cycles spent busy
	always_ff @(posedge sys_clk) begin
		busy_cnt_q <= (!resetn || !flash_status_word[0]) ? 16'h0000
			: busy_cnt_q + 16'h0001;
	end
	// ==========================================================
	// properties
	a_reset_status_zero: assert property ($rose(resetn) |->
		flash_status_word == 8'h00 && serial_out_oe_n)
		else $error("status not cleared by reset");
	a_reserved_reads_zero: assert property (!flash_status_word[6])
		else $error("reserved bit set");
	a_busy_bounded: assert property (busy_cnt_q <=
		16'(WRSR_CYC + PROG_CYC + ERASE_CYC))
		else $error("busy never ends");
	a_busy_end_clears: assert property ($fell(flash_status_word[0])
		|-> !flash_status_word[1]) else $error("latch kept after busy");
	a_latch_set_idle: assert property ($rose(flash_status_word[1])
		|-> !$past(flash_status_word[0])) else $error("latch set busy");
	a_op_needs_latch: assert property (array_op_start |->
		flash_status_word[1] && !flash_status_word[0])
		else $error("op without latch");
	a_op_one_cycle: assert property (array_op_start |=>
		!array_op_start && flash_status_word[0]) else $error("op pulse");
	a_op_code_legal: assert property (array_op_start |->
		array_op_code inside {`OP_PP, `OP_SE, `OP_BE32, `OP_BE64,
		`OP_CE1, `OP_CE2}) else $error("bad op code");
	a_lock_keeps_bits: assert property ((flash_status_word[7]
		&& !write_protect_pin_n)[*8] |=> $stable(flash_status_word[7:2]))
		else $error("locked bits changed");
	a_oe_off_deselect: assert property ($rose(chip_select_n) |->
		##[1:6] serial_out_oe_n) else $error("output kept on");
	c_op: cover property (array_op_start);
	c_busy_end: cover property ($fell(flash_status_word[0]));
	c_locked: cover property (flash_status_word[7] && !write_protect_pin_n);
endmodule // flash_status_wp_properties
bind flash_status_wp flash_status_wp_properties #(.WRSR_CYC(WRSR_CYC),
	.PROG_CYC(PROG_CYC), .ERASE_CYC(ERASE_CYC)) i_flash_status_wp_properties
	(.sys_clk, .resetn, .chip_select_n, .serial_clk, .serial_in,
	.write_protect_pin_n, .serial_out, .serial_out_oe_n,
	.flash_status_word, .array_op_start, .array_op_code, .array_op_addr);

// [spi_host_model.sv]
// spi host model: select, clock and data toward the device
`timescale 1ns/1ps
module spi_host_model (
	input  wire  sys_clk, // bench clock
	input  wire  miso,    // device data out
	output logic cs_n,    // select, low active
	output logic sck,     // serial clock, low when idle
	output logic mosi     // data to device
);
	initial begin
		cs_n = 1'b1;
		sck  = 1'b0;
		mosi = 1'b0;
	end
	// ==========================================================
	// one frame: nb bits sent msb first, then nr bits read
	// framing msb first
	task automatic frame(input logic [31:0] d, input int nb,
		input int nr, output logic [15:0] rd);
		rd = 16'h0000;
		@(posedge sys_clk) cs_n <= 1'b0;
		repeat (4) @(posedge sys_clk);
		for (int i = 0; i < nb + nr; i++) begin
			// unused data line toggles, never a stale value
			mosi <= (i < nb) ? d[31 - i] : ~mosi;
			repeat (4) @(posedge sys_clk);
			sck <= 1'b1;
			repeat (4) @(posedge sys_clk);
			// capture just before the fall that moves the data
			if (i >= nb) rd = {rd[14:0], miso};
			sck <= 1'b0;
		end
		repeat (4) @(posedge sys_clk);
		cs_n <= 1'b1;
		mosi <= ~mosi;
		repeat (8) @(posedge sys_clk);
	endtask
endmodule // spi_host_model

// [flash_status_wp_test.sv]
// self-checking bench for the status word and write protection
`timescale 1ns/1ps
`include "flash_status_defines.vh"
module flash_status_wp_test;
	logic        sys_clk = 1'b0;          // 20 MHz
	logic        resetn = 1'b0;           // sync reset
	logic        write_protect_pin_n = 1'b1; // protect pin
	wire         chip_select_n, serial_clk, serial_in;
	wire         serial_out, serial_out_oe_n, array_op_start;
	wire  [7:0]  flash_status_word, array_op_code;
	wire  [23:0] array_op_addr;
	int          compares = 0, miscompares = 0;
	int          seed = 32'h38e5dc83;     // random seed
	logic [15:0] exp_q [$], e;            // {mask, value} notes
	logic [31:0] op_q [$], o;             // {code, addr} notes
	logic [15:0] rd_v;                    // two status bytes read
	logic [23:0] a;                       // program or erase address
	logic [7:0]  c;                       // program or erase opcode
	event        rd_ev;                   // a read has ended
	// table {status, sector}; ok bit set where erase is allowed
	logic [31:0] tbl [15] = '{32'h0406f000, 32'h04070000, 32'h0805f000,
		32'h08060000, 32'h0c03f000, 32'h0c040000, 32'h24010000,
		32'h2400f000, 32'h28020000, 32'h2801f000, 32'h2c040000,
		32'h2c03f000, 32'h1007f000, 32'h30000000, 32'h20000000};
	logic [14:0] ok = 15'h4555;
	always #25 sys_clk = ~sys_clk;
	flash_status_wp #(.WRSR_CYC(600), .PROG_CYC(10), .ERASE_CYC(10))
		i_flash_status_wp (.sys_clk, .resetn, .chip_select_n,
		.serial_clk, .serial_in, .write_protect_pin_n, .serial_out,
		.serial_out_oe_n, .flash_status_word, .array_op_start,
		.array_op_code, .array_op_addr);
	// a released output reads as the inverse of its last level
	spi_host_model i_spi_host_model (.sys_clk,
		.miso(serial_out_oe_n ? ~serial_out : serial_out),
		.cs_n(chip_select_n), .sck(serial_clk), .mosi(serial_in));
	// ==========================================================
	// tasks
	task automatic summarize;
		$display("compares=%0d miscompares=%0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic cmd(input logic [31:0] d, input int nb);
		logic [15:0] r;
		i_spi_host_model.frame(d, nb, 0, r);
	endtask
	task automatic rd_st(input logic [7:0] m, input logic [7:0] v);
		i_spi_host_model.frame({`OP_RDSR, 24'h0}, 8, 16, rd_v);
		exp_q.push_back({m, v});
		-> rd_ev;
	endtask
	task automatic wait_idle;
		int n;
		n = 0;
		repeat (6) @(posedge sys_clk);
		while (flash_status_word[0] !== 1'b0 && n < 2000) begin
			@(posedge sys_clk);
			n++;
		end
		if (n >= 2000) begin
			miscompares++;
			summarize();
		end
	endtask
	task automatic wsr(input logic [7:0] v);
		cmd({`OP_WREN, 24'h0}, 8);
		cmd({`OP_WRSR, v, 16'h0}, 16);
		wait_idle();
	endtask
	// ==========================================================
	// result watchers
	always @(rd_ev) begin
		e = exp_q.pop_front();
		compares++;
		// byte repeats: both bytes read must match
		if ((rd_v & {2{e[15:8]}}) !== {2{e[7:0] & e[15:8]}}) begin
			miscompares++;
			$display("[ERR] %0t got %h exp %h", $time, rd_v, e);
		end
	end
	always @(posedge sys_clk) if (array_op_start === 1'b1) begin
		compares++;
		o = (op_q.size() > 0) ? op_q.pop_front() : 32'hx;
		if ({array_op_code, array_op_addr} !== o) begin
			miscompares++;
			$display("[ERR] %0t got %h exp %h", $time,
				{array_op_code, array_op_addr}, o);
		end
	end
	initial begin
		repeat (95000) @(posedge sys_clk);
		miscompares++;
		summarize();
	end
	// ==========================================================
	// main sequence
	initial begin
		repeat (4) @(posedge sys_clk);
		resetn <= 1'b1;
		repeat (6) @(posedge sys_clk);
		rd_st(8'hff, 8'h00);
		cmd({`OP_WREN, 24'h0}, 7);
		rd_st(8'hff, 8'h00);
		cmd({`OP_WRSR, 8'h9c, 16'h0}, 16);
		rd_st(8'hff, 8'h00);
		cmd({`OP_VWREN, 24'h0}, 8);
		cmd({`OP_WRSR, 8'h04, 16'h0}, 16);
		rd_st(8'hff, 8'h04);
		cmd({`OP_VWREN, 24'h0}, 8);
		cmd({`OP_WRSR, 8'h00, 16'h0}, 16);
		cmd({`OP_WREN, 24'h0}, 8);
		rd_st(8'hff, 8'h02);
		cmd({`OP_WRSR, 8'h0c, 16'h0}, 16);
		cmd({`OP_WRDI, 24'h0}, 8);
		rd_st(8'h03, 8'h03);
		wait_idle();
		rd_st(8'hff, 8'h0c);
		// protected regions; pin level is random while unlocked
		for (int k = 0; k < 15; k++) begin
			write_protect_pin_n <= 1'($random(seed));
			a = tbl[k][23:0] | (24'($random(seed)) & 24'h000fff);
			wsr(tbl[k][31:24]);
			cmd({`OP_WREN, 24'h0}, 8);
			if (ok[k]) op_q.push_back({`OP_SE, a});
			cmd({`OP_SE, a}, 32);
			wait_idle();
			rd_st(8'hbc, tbl[k][31:24]);
		end
		// program and block erases under upper 1/8, chip erases
		wsr(8'h04);
		for (int k = 0; k < 8; k++) begin
			c = (k % 4 == 0) ? `OP_PP : (k % 4 == 1) ? `OP_BE32
				: (k % 4 == 2) ? `OP_BE64 : `OP_CE2;
			a = (k < 4 ? 24'h068000 : 24'h070000)
				| (24'($random(seed)) & 24'h007fff);
			cmd({`OP_WREN, 24'h0}, 8);
			if (k < 3) op_q.push_back({c, a});
			cmd({c, a}, (c == `OP_CE2) ? 8 : 32);
			wait_idle();
		end
		wsr(8'h00);
		cmd({`OP_WREN, 24'h0}, 8);
		op_q.push_back({`OP_CE1, 24'h0});
		cmd({`OP_CE1, 24'h0}, 8);
		wait_idle();
		write_protect_pin_n <= 1'b1;
		wsr(8'h80);
		write_protect_pin_n <= 1'b0;
		repeat (8) @(posedge sys_clk);
		wsr(8'h9c);
		rd_st(8'hbd, 8'h80);
		write_protect_pin_n <= 1'b1;
		wsr(8'h00);
		rd_st(8'hff, 8'h00);
		// let the read watcher take the last note
		repeat (2) @(posedge sys_clk);
		if (op_q.size() != 0) miscompares++;
		summarize();
	end
endmodule // flash_status_wp_test
